/* tcs_defs.vh */
// Purpose: constants for the temperature channel trip voting block
// Assumes: included by bare name from every design file
// Notes: definitions only
`ifndef TCS_DEFS_VH
`define TCS_DEFS_VH

// ****************************************************************
// channel layout
// ****************************************************************
`define TCS_NCH 12
`define TCS_NGRP 4
`define TCS_NEV 16
// group member masks {aux, ambient, winding 2, winding 1}
`define TCS_GRP_MASKS 48'hF000C0038007
`define TCS_TW 16

// ****************************************************************
// hysteresis: release at 99 of 100 percent of threshold
// ****************************************************************
`define TCS_PCT_FULL 7'h64
`define TCS_PCT_DROP 7'h63

// ****************************************************************
// bus map, byte address bits [7:0]
// ****************************************************************
`define TCS_RGN_CTRL 2'h0
`define TCS_RGN_THR 2'h1
`define TCS_RGN_DLY 2'h2
`define TCS_RGN_TEMP 2'h3
`define TCS_IDX_CTRL 4'h0
`define TCS_IDX_CHEN 4'h1
`define TCS_IDX_VOTE0 4'h2
`define TCS_IDX_VOTE1 4'h3
`define TCS_IDX_STAT 4'h4
`define TCS_IDX_TRIP 4'h5
`define TCS_IDX_ALARM 4'h6
`define TCS_IDX_TMO 4'h7

// ****************************************************************
// fields and reset values
// ****************************************************************
`define TCS_CTRL_MOD_EN 0
`define TCS_CTRL_TSEL 1
`define TCS_VOTE_EN 8
`define TCS_VOTE_CNT_LSB 0
`define TCS_VOTE_MASK_LSB 16
`define TCS_HSIZE_WORD 3'h2
`define TCS_HTRANS_NSEQ_BIT 1
`define TCS_THR_RST 32'h00000000
`define TCS_DLY_RST 8'h00
`define TCS_WORD_ZERO 32'h00000000
`define TCS_TEMP_ZERO 16'h0000
`endif

/* tcs_chan_eval.v */
// Purpose: one temperature comparison stage with hysteresis and delayed alarm
// Assumes: eval pulses once per received frame
// Notes: delay is counted in frames, not clock cycles
`default_nettype none
`include "tcs_defs.vh"

module tcs_chan_eval (
  input wire mclk,
  input wire rst,
  input wire eval,
  input wire enable,
  input wire [15:0] temp,
  input wire [15:0] trip_thr,
  input wire [15:0] alarm_thr,
  input wire [7:0] delay,
  output wire trip,
  output wire alarm_raw,
  output wire alarm
);

  reg trip_reg;
  reg trip_next;
  reg raw_reg;
  reg raw_next;
  reg alarm_reg;
  reg alarm_next;
  reg [7:0] cnt_reg;
  reg [7:0] cnt_next;
  wire [22:0] temp_x;
  wire [22:0] trip_x;
  wire [22:0] alarm_x;

  // scaled compare avoids a divider for the 0.99 release point
  assign temp_x = temp * `TCS_PCT_FULL;
  assign trip_x = trip_thr * `TCS_PCT_DROP;
  assign alarm_x = alarm_thr * `TCS_PCT_DROP;

  // set above threshold, release at or below 0.99 of it
  always @* begin
    trip_next = trip_reg;
    raw_next = raw_reg;
    cnt_next = cnt_reg;
    alarm_next = alarm_reg;
    if (eval) begin
      if (!enable) begin
        trip_next = 1'b0;
        raw_next = 1'b0;
      end else begin
        if (temp > trip_thr) begin
          trip_next = 1'b1; // RL6
        end else if (temp_x <= trip_x) begin
          trip_next = 1'b0; // RL13
        end
        if (temp > alarm_thr) begin
          raw_next = 1'b1;
        end else if (temp_x <= alarm_x) begin
          raw_next = 1'b0; // RL13
        end
      end
      // alarm only after raw has held for the set number of frames
      if (!raw_next) begin
        cnt_next = 8'h00;
      end else if (cnt_reg < delay) begin
        cnt_next = cnt_reg + 8'h01;
      end
      // judged on frames already held, so a delay of one waits a frame
      alarm_next = raw_next && (cnt_reg >= delay); // RL6
    end
  end

  // state update
  always @(posedge mclk) begin
    if (rst) begin
      trip_reg <= 1'b0;
      raw_reg <= 1'b0;
      alarm_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else begin
      trip_reg <= trip_next;
      raw_reg <= raw_next;
      alarm_reg <= alarm_next;
      cnt_reg <= cnt_next;
    end
  end

  assign trip = trip_reg;
  assign alarm_raw = raw_reg;
  assign alarm = alarm_reg;

endmodule
`default_nettype wire

/* tcs_trip_voting.v */
// Purpose: per-channel, group, collective and voting temperature trips
// Assumes: channel words arrive synchronous to mclk, last word flagged
// Notes: AHB-Lite slave, reads take one wait state, writes none
//
// Contract
// RL1: twelve channels sort into six winding, two ambient and four auxiliary, with group settings and status.
// RL2: each group is judged on the hottest active channel in it.
// RL3: a voting scheme gives no trip unless its enable is set.
// RL4: a voting scheme trips when its count of selected channels above threshold reaches its voting number.
// RL5: a channel counts only when selected, active, and the whole module is active.
// RL6: each channel alarms after a settable delay and trips at once above its trip threshold.
// RL7: the four groups OR into a collective alarm, timeout and trip.
// RL8: the collective timeout is the OR of all sensor and group timeouts.
// RL9: a selector takes the final trip from default trips or from voting trips.
// RL10: the block input suppresses every trip output.
// RL11: up to twelve channel values are accepted, shown and monitored.
// RL12: the remote module sends all values multiplexed on one fiber.
// RL13: trip and alarm release only at 0.99 of their thresholds.
// RL14: everything is re-evaluated after each complete received frame.
`default_nettype none
`include "tcs_defs.vh"

module tcs_trip_voting (
  input wire mclk,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire temp_valid,
  input wire [3:0] temp_chan,
  input wire [15:0] temp_value,
  input wire temp_last,
  input wire block_trip,
  output wire coll_alarm,
  output wire coll_timeout,
  output wire coll_trip,
  output wire [1:0] vote_trip,
  output wire prot_trip
);

  // ****************************************************************
  // storage
  // ****************************************************************
  reg [31:0] thr_reg [0:15];
  reg [7:0] dly_reg [0:15];
  reg [15:0] temp_reg [0:11];
  reg [1:0] ctrl_reg;
  reg [11:0] chen_reg;
  reg [31:0] vote0_reg;
  reg [31:0] vote1_reg;
  reg [11:0] seen_reg;
  reg [11:0] tmo_reg;
  reg [3:0] gtmo_reg;
  reg eval_reg;
  reg comb_reg;
  reg coll_alarm_reg;
  reg coll_tmo_reg;
  reg coll_trip_reg;
  reg [1:0] vote_reg;
  reg prot_trip_reg;
  reg [31:0] hrdata_reg;
  reg hready_reg;
  reg wr_reg;
  reg rd_reg;
  reg [7:0] addr_reg;
  reg [15:0] gmax [0:3];
  reg [15:0] ev_temp [0:15];
  reg [15:0] ev_en;
  reg [3:0] vcnt0;
  reg [3:0] vcnt1;
  reg [11:0] tmo_next;
  reg [3:0] gtmo_next;
  reg [31:0] rd_mux;
  wire [15:0] ev_trip;
  wire [15:0] ev_raw;
  wire [15:0] ev_alarm;
  wire mod_en;
  wire [11:0] ch_act;
  wire [11:0] vsel0;
  wire [11:0] vsel1;
  wire vote0_hit;
  wire vote1_hit;
  wire def_trip;
  wire any_trip;
  wire addr_ok;
  wire wr_ok;
  wire [1:0] rgn;
  wire [3:0] idx;
  wire [47:0] grp_masks;
  integer i;
  integer g;
  genvar k;

  assign mod_en = ctrl_reg[`TCS_CTRL_MOD_EN];
  assign ch_act = chen_reg & {`TCS_NCH{mod_en}};
  assign grp_masks = `TCS_GRP_MASKS;

  // ****************************************************************
  // frame capture
  // ****************************************************************
  // values land in the array as they arrive; last word schedules eval
  always @(posedge mclk) begin
    if (rst) begin
      eval_reg <= 1'b0;
      comb_reg <= 1'b0;
      seen_reg <= 12'h000;
      for (i = 0; i < `TCS_NCH; i = i + 1) begin
        temp_reg[i] <= `TCS_TEMP_ZERO;
      end
    end else begin
      eval_reg <= temp_valid && temp_last; // RL14
      comb_reg <= eval_reg;
      for (i = 0; i < `TCS_NCH; i = i + 1) begin
        // a word arriving in the clear cycle still marks its channel
        if (temp_valid && (temp_chan == i)) begin
          temp_reg[i] <= temp_value; // RL11
          seen_reg[i] <= 1'b1;
        end else if (eval_reg) begin
          seen_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // group maxima and evaluator inputs
  // ****************************************************************
  // inactive members read as zero so they never win the maximum
  always @* begin
    for (g = 0; g < `TCS_NGRP; g = g + 1) begin
      gmax[g] = `TCS_TEMP_ZERO;
      ev_en[`TCS_NCH + g] = 1'b0;
      for (i = 0; i < `TCS_NCH; i = i + 1) begin
        if (grp_masks[g * `TCS_NCH + i] && ch_act[i]) begin
          ev_en[`TCS_NCH + g] = 1'b1; // RL1
          if (temp_reg[i] > gmax[g]) begin
            gmax[g] = temp_reg[i]; // RL2
          end
        end
      end
      ev_temp[`TCS_NCH + g] = gmax[g];
    end
    for (i = 0; i < `TCS_NCH; i = i + 1) begin
      ev_temp[i] = temp_reg[i];
      ev_en[i] = ch_act[i];
    end
  end

  // twelve channels plus four groups share one evaluator design
  generate
    for (k = 0; k < `TCS_NEV; k = k + 1) begin : g_ev
      tcs_chan_eval u_ev (
        .mclk(mclk),
        .rst(rst),
        .eval(eval_reg),
        .enable(ev_en[k]),
        .temp(ev_temp[k]),
        .trip_thr(thr_reg[k][15:0]),
        .alarm_thr(thr_reg[k][31:16]),
        .delay(dly_reg[k]),
        .trip(ev_trip[k]),
        .alarm_raw(ev_raw[k]),
        .alarm(ev_alarm[k])
      );
    end
  endgenerate

  // ****************************************************************
  // timeout monitor
  // ****************************************************************
  // an active channel missing from a frame is a sensor timeout
  always @* begin
    tmo_next = ch_act & ~seen_reg;
    for (g = 0; g < `TCS_NGRP; g = g + 1) begin
      gtmo_next[g] = |(tmo_next & grp_masks[g * `TCS_NCH +: `TCS_NCH]);
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      tmo_reg <= 12'h000;
      gtmo_reg <= 4'h0;
    end else if (eval_reg) begin
      tmo_reg <= tmo_next;
      gtmo_reg <= gtmo_next;
    end
  end

  // ****************************************************************
  // voting
  // ****************************************************************
  assign vsel0 = vote0_reg[`TCS_VOTE_MASK_LSB +: `TCS_NCH] & ch_act; // RL5
  assign vsel1 = vote1_reg[`TCS_VOTE_MASK_LSB +: `TCS_NCH] & ch_act; // RL5

  // count selected channels above their own trip threshold
  always @* begin
    vcnt0 = 4'h0;
    vcnt1 = 4'h0;
    for (i = 0; i < `TCS_NCH; i = i + 1) begin
      vcnt0 = vcnt0 + {3'h0, vsel0[i] & ev_trip[i]};
      vcnt1 = vcnt1 + {3'h0, vsel1[i] & ev_trip[i]};
    end
  end

  // a voting number of zero never trips, avoiding a trip with no cause
  assign vote0_hit = vote0_reg[`TCS_VOTE_EN] && (vote0_reg[3:0] != 4'h0) &&
    (vcnt0 >= vote0_reg[3:0]); // RL3 RL4
  assign vote1_hit = vote1_reg[`TCS_VOTE_EN] && (vote1_reg[3:0] != 4'h0) &&
    (vcnt1 >= vote1_reg[3:0]); // RL3 RL4

  // ****************************************************************
  // collective outputs
  // ****************************************************************
  assign def_trip = |ev_trip;
  assign any_trip = ctrl_reg[`TCS_CTRL_TSEL] ? (vote0_hit | vote1_hit) : def_trip; // RL9

  // combined one cycle after the evaluators settle
  always @(posedge mclk) begin
    if (rst) begin
      coll_alarm_reg <= 1'b0;
      coll_tmo_reg <= 1'b0;
      coll_trip_reg <= 1'b0;
      vote_reg <= 2'h0;
      prot_trip_reg <= 1'b0;
    end else begin
      if (comb_reg) begin
        coll_alarm_reg <= |ev_alarm; // RL7
        coll_tmo_reg <= (|tmo_reg) | (|gtmo_reg); // RL7 RL8
      end
      // block acts at once, not only at the next frame
      if (block_trip) begin
        coll_trip_reg <= 1'b0; // RL10
        vote_reg <= 2'h0; // RL10
        prot_trip_reg <= 1'b0; // RL10
      end else if (comb_reg) begin
        coll_trip_reg <= def_trip; // RL7
        vote_reg <= {vote1_hit, vote0_hit};
        prot_trip_reg <= any_trip; // RL9
      end
    end
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  assign addr_ok = hsel && hready && htrans[`TCS_HTRANS_NSEQ_BIT];
  assign rgn = addr_reg[7:6];
  assign idx = addr_reg[5:2];
  assign wr_ok = wr_reg && (addr_reg[1:0] == 2'h0);

  // read mux; unmapped and reserved bits read as zero
  always @* begin
    rd_mux = `TCS_WORD_ZERO;
    case (rgn)
      `TCS_RGN_CTRL: begin
        case (idx)
          `TCS_IDX_CTRL: rd_mux = {30'h00000000, ctrl_reg};
          `TCS_IDX_CHEN: rd_mux = {20'h00000, chen_reg};
          `TCS_IDX_VOTE0: rd_mux = vote0_reg;
          `TCS_IDX_VOTE1: rd_mux = vote1_reg;
          `TCS_IDX_STAT: rd_mux = {26'h0000000, prot_trip_reg, vote_reg, coll_trip_reg, coll_tmo_reg,
            coll_alarm_reg};
          `TCS_IDX_TRIP: rd_mux = {16'h0000, ev_trip};
          `TCS_IDX_ALARM: rd_mux = {ev_raw, ev_alarm};
          `TCS_IDX_TMO: rd_mux = {16'h0000, gtmo_reg, tmo_reg};
          default: rd_mux = `TCS_WORD_ZERO;
        endcase
      end
      `TCS_RGN_THR: rd_mux = thr_reg[idx];
      `TCS_RGN_DLY: rd_mux = {24'h000000, dly_reg[idx]};
      `TCS_RGN_TEMP: rd_mux = {16'h0000, ev_temp[idx]};
      default: rd_mux = `TCS_WORD_ZERO;
    endcase
  end

  // reads wait one cycle so a write just before them is visible
  always @(posedge mclk) begin
    if (rst) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      addr_reg <= 8'h00;
      hready_reg <= 1'b1;
      hrdata_reg <= `TCS_WORD_ZERO;
    end else begin
      rd_reg <= 1'b0;
      hready_reg <= 1'b1;
      if (hready_reg) begin
        wr_reg <= addr_ok && hwrite && (hsize == `TCS_HSIZE_WORD);
        if (addr_ok) begin
          addr_reg <= haddr[7:0];
          rd_reg <= !hwrite;
          hready_reg <= hwrite;
        end
      end
      if (rd_reg) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // register writes in the data phase
  always @(posedge mclk) begin
    if (rst) begin
      ctrl_reg <= 2'h0;
      chen_reg <= 12'h000;
      vote0_reg <= `TCS_WORD_ZERO;
      vote1_reg <= `TCS_WORD_ZERO;
      for (i = 0; i < `TCS_NEV; i = i + 1) begin
        thr_reg[i] <= `TCS_THR_RST;
        dly_reg[i] <= `TCS_DLY_RST;
      end
    end else if (wr_ok) begin
      case (rgn)
        `TCS_RGN_CTRL: begin
          case (idx)
            `TCS_IDX_CTRL: ctrl_reg <= hwdata[1:0];
            `TCS_IDX_CHEN: chen_reg <= hwdata[11:0];
            `TCS_IDX_VOTE0: vote0_reg <= hwdata & 32'h0FFF010F;
            `TCS_IDX_VOTE1: vote1_reg <= hwdata & 32'h0FFF010F;
            default: ctrl_reg <= ctrl_reg;
          endcase
        end
        `TCS_RGN_THR: thr_reg[idx] <= hwdata;
        `TCS_RGN_DLY: dly_reg[idx] <= hwdata[7:0];
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hready_reg;
  assign hresp = 1'b0;
  assign coll_alarm = coll_alarm_reg;
  assign coll_timeout = coll_tmo_reg;
  assign coll_trip = coll_trip_reg;
  assign vote_trip = vote_reg;
  assign prot_trip = prot_trip_reg;

endmodule
`default_nettype wire

/* tcs_chk.sv */
// Purpose: port-level assertions for the trip voting block
// Assumes: one clock, synchronous active-high reset
// Notes: attached by the bind after the module
`default_nettype none
module tcs_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic temp_valid,
  input wire logic temp_last,
  input wire logic block_trip,
  input wire logic coll_alarm,
  input wire logic coll_timeout,
  input wire logic coll_trip,
  input wire logic [1:0] vote_trip,
  input wire logic prot_trip
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // bus request taken, and the one wait state of a read
  sequence s_rd_take;
    hsel && hready && htrans[1] && !hwrite && hreadyout;
  endsequence
  sequence s_wr_take;
    hsel && hready && htrans[1] && hwrite && hreadyout;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_wait: assert property (s_rd_take |=> s_one_wait) else $error("read wait state wrong");
  a_write_nowait: assert property (s_wr_take |=> hreadyout) else $error("write stalled");
  a_wait_cause: assert property ($fell(hreadyout) |-> $past(hsel) && $past(htrans[1]) && !$past(hwrite))
    else $error("wait state without read");
  a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout)) else $error("read data moved");
  a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  a_block_clear: assert property (block_trip |=> !coll_trip && !prot_trip && vote_trip == 2'h0)
    else $error("trip passed while blocked");
  a_final_source: assert property (prot_trip |-> coll_trip || vote_trip != 2'h0)
    else $error("final trip without source");
  // outputs may only move two edges after a frame end or after a block change
  a_frame_update: assert property ($changed({coll_alarm, coll_timeout, coll_trip, vote_trip, prot_trip}) |->
    ($past(temp_valid, 3) && $past(temp_last, 3)) || $past(block_trip) || $past(block_trip, 2))
    else $error("outputs moved outside frame");
endmodule
bind tcs_trip_voting tcs_chk i_tcs_chk (.mclk(mclk), .rst(rst), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .temp_valid(temp_valid), .temp_last(temp_last), .block_trip(block_trip), .coll_alarm(coll_alarm),
  .coll_timeout(coll_timeout), .coll_trip(coll_trip), .vote_trip(vote_trip), .prot_trip(prot_trip));
`default_nettype wire

/* tcs_far_end.sv */
// Purpose: remote acquisition end, sends one frame of channel words
// Assumes: driven just after rising edges of mclk
// Notes: idle lines show the inverse of the last word, so stale data cannot pass
`default_nettype none
module tcs_far_end (
  input wire logic mclk,
  output var logic temp_valid,
  output var logic [3:0] temp_chan,
  output var logic [15:0] temp_value,
  output var logic temp_last
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet link at time zero
  initial begin
    temp_valid = 1'b0;
    temp_chan = 4'hF;
    temp_value = 16'h0000;
    temp_last = 1'b0;
  end
  // all channels share one multiplexed stream; skip[11] must stay clear
  task automatic send_frame(input logic [15:0] base, input logic [15:0] hot, input logic [11:0] hot_mask,
    input logic [11:0] skip);
    for (int i = 0; i < 12; i++) begin
      if (!skip[i]) begin
        @(posedge mclk);
        temp_valid <= 1'b1;
        temp_chan <= 4'(i);
        temp_value <= hot_mask[i] ? hot : base;
        temp_last <= (i == 11);
      end
    end
    @(posedge mclk);
    temp_valid <= 1'b0;
    temp_last <= 1'b0;
    temp_chan <= ~temp_chan;
    temp_value <= ~temp_value;
  endtask
endmodule
`default_nettype wire

/* tcs_tb.sv */
// Purpose: self-checking bench for the trip voting block
// Assumes: trip threshold 1000, alarm 800, all delays one frame
// Notes: each frame is judged three edges after its last word
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, hsel, hwrite, block_trip, hreadyout, hresp;
  logic temp_valid, temp_last, coll_alarm, coll_timeout, coll_trip, prot_trip;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, vote_trip;
  logic [2:0] hsize;
  logic [3:0] temp_chan;
  logic [15:0] temp_value;
  int n_mismatch, total_checks;

  tcs_trip_voting i_tcs_trip_voting (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .temp_valid(temp_valid), .temp_chan(temp_chan),
    .temp_value(temp_value), .temp_last(temp_last), .block_trip(block_trip), .coll_alarm(coll_alarm),
    .coll_timeout(coll_timeout), .coll_trip(coll_trip), .vote_trip(vote_trip), .prot_trip(prot_trip));
  tcs_far_end i_tcs_far_end (.mclk(mclk), .temp_valid(temp_valid), .temp_chan(temp_chan),
    .temp_value(temp_value), .temp_last(temp_last));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task print_verdict;
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait for hready high at a rising edge
  task wait_ready;
    int k;
    k = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1 && k < 20) begin
      @(posedge mclk);
      k++;
    end
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: bus never ready", $time);
      print_verdict;
    end
  endtask

  // tasks start just after an edge, so requests run back to back
  task bus_write(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= d;
    wait_ready;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    wait_ready;
    rd = hrdata;
    chk(rd, exp);
  endtask

  // one frame, base 500 on cold channels, then ports and status word
  task frame_chk(input logic [15:0] hot, input logic [11:0] hot_mask, input logic [11:0] skip,
    input logic [31:0] exp);
    i_tcs_far_end.send_frame(16'h01F4, hot, hot_mask, skip);
    repeat (3) @(posedge mclk);
    chk({26'h0000000, prot_trip, vote_trip, coll_trip, coll_timeout, coll_alarm}, exp);
    rd_chk(8'h10, exp);
  endtask

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    block_trip = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(8'h10, 32'h00000000);
    rd_chk(8'h00, 32'h00000000);
    rd_chk(8'h20, 32'h00000000);
    bus_write(8'h00, 32'h00000001);
    bus_write(8'h04, 32'h00000FFF);
    for (int n = 0; n < 16; n++) begin
      bus_write(8'h40 + 8'(4 * n), 32'h032003E8);
      bus_write(8'h80 + 8'(4 * n), 32'h00000001);
    end
    rd_chk(8'h44, 32'h032003E8);
    frame_chk(16'h01F4, 12'h000, 12'h000, 32'h00000000);
    frame_chk(16'h044C, 12'h002, 12'h000, 32'h00000024);
    rd_chk(8'h14, 32'h00001002);
    rd_chk(8'hF0, 32'h0000044C);
    frame_chk(16'h044C, 12'h002, 12'h000, 32'h00000025);
    // 995 holds the trip, 990 is exactly 0.99 of 1000 and releases it
    frame_chk(16'h03E3, 12'h002, 12'h000, 32'h00000025);
    frame_chk(16'h03DE, 12'h002, 12'h000, 32'h00000001);
    frame_chk(16'h01F4, 12'h000, 12'h020, 32'h00000002);
    bus_write(8'h08, 32'h000F0002);
    bus_write(8'h0C, 32'h00100101);
    bus_write(8'h00, 32'h00000003);
    rd_chk(8'h08, 32'h000F0002);
    frame_chk(16'h044C, 12'h003, 12'h000, 32'h00000004);
    bus_write(8'h08, 32'h000F0102);
    frame_chk(16'h044C, 12'h003, 12'h000, 32'h0000002D);
    frame_chk(16'h044C, 12'h011, 12'h000, 32'h00000035);
    bus_write(8'h00, 32'h00000002);
    frame_chk(16'h044C, 12'h011, 12'h000, 32'h00000000);
    bus_write(8'h00, 32'h00000003);
    block_trip <= 1'b1;
    frame_chk(16'h044C, 12'h011, 12'h000, 32'h00000000);
    block_trip <= 1'b0;
    frame_chk(16'h044C, 12'h011, 12'h000, 32'h00000035);
    print_verdict;
  end
endmodule
`default_nettype wire
